// ===== inc/wbm_pkg.sv
// shared constants and types of the word and bit manipulation unit
package wbm_pkg;

    localparam logic [15:0] WBM_ERR_RANGE    = 16'h2003;
    localparam logic [15:0] WBM_ERR_OPERAND  = 16'h200B;
    localparam logic [15:0] WBM_ERR_CODE_RST = 16'h0000;

    localparam logic [15:0] WBM_PACK_MIN     = 16'h0001;
    localparam logic [15:0] WBM_PACK_MAX     = 16'h0004;
    localparam logic [15:0] WBM_SUM_MAX      = 16'h0100;
    localparam logic [15:0] WBM_SUM_WIDE_MAX = 16'h0080;
    localparam logic [15:0] WBM_BIT_MAX      = 16'h000F;
    localparam logic [15:0] WBM_BLOCK_RESET_OP_MAX    = 16'h0400;

    localparam int          WBM_NIB_W        = 4;
    localparam int          WBM_CNT_W        = 11;

    typedef enum logic [2:0] {
        nibble_pack_op      = 3'h0,
        block_sum_op        = 3'h1,
        block_sum_wide_op   = 3'h2,
        bit_set_op          = 3'h3,
        bit_clear_op        = 3'h4,
        block_reset_op      = 3'h5,
        bound_clamp_wide_op = 3'h6
    } wbm_op_e;

    typedef enum logic [1:0] {
        WBM_LEN_WORD   = 2'h0,
        WBM_LEN_DOUBLE = 2'h1,
        WBM_LEN_LONG   = 2'h2
    } wbm_len_e;

    typedef struct packed {
        logic        valid;
        wbm_op_e     op;
        logic        tc_target;
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] src_end;
        logic [15:0] dst_end;
        logic [15:0] count;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] opc;
    } wbm_cmd_s;

    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        wbm_len_e    len;
        logic        aux_clr;
        logic [63:0] data;
    } wbm_wr_s;

endpackage

// ===== logic/wbm_clamp.sv
// signed bound clamp with bound order check
`timescale 1ns/10ps
`default_nettype none
module wbm_clamp #(
    parameter int W = 32
) (
    // operands
    input  wire logic [W-1:0] lo_i,
    input  wire logic [W-1:0] hi_i,
    input  wire logic [W-1:0] x_i,
    // result
    output logic      [W-1:0] y_o,
    output logic              bad_o
);
    if (W < 2) begin : g_chk
        $error("clamp width too small");
    end

    assign bad_o = $signed(lo_i) > $signed(hi_i);

    always_comb begin
        if ($signed(x_i) < $signed(lo_i)) begin
            y_o = lo_i;
        end else if ($signed(x_i) > $signed(hi_i)) begin
            y_o = hi_i;
        end else begin
            y_o = x_i;
        end
    end
endmodule
`default_nettype wire

// ===== logic/wbm_unit.sv
// word and bit manipulation execution unit
`timescale 1ns/10ps
`default_nettype none
module wbm_unit
    import wbm_pkg::*;
#(
    parameter int DW = 32
) (
    // clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    // command from sequencer
    input  wire wbm_pkg::wbm_cmd_s  cmd_i,
    output logic                    busy_o,
    output logic                    done_o,
    // source word stream
    input  wire logic               src_valid_i,
    input  wire logic [DW-1:0]      src_data_i,
    output logic                    src_ready_o,
    // destination write port
    output wbm_pkg::wbm_wr_s        wr_o,
    // error status
    input  wire logic               err_clr_i,
    output logic                    operation_error_flag_o,
    output logic [15:0]             error_code_register_o
);
    import wbm_pkg::*;

    if (DW != 32) begin : g_chk
        $error("source width must be 32");
    end

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_CLEAR = 3'b100
    } wbm_st_e;

    wbm_st_e               state_q;
    wbm_op_e               op_q;
    logic                  tc_q;
    logic [WBM_CNT_W-1:0]  cnt_q;
    logic [1:0]            nib_q;
    logic [15:0]           addr_q;
    logic [15:0]           pack_q;
    logic [63:0]           acc_q;
    logic [63:0]           acc_d;
    logic [15:0]           pack_d;
    wbm_wr_s               wr_q;
    logic                  busy_q;
    logic                  done_q;
    logic                  rdy_q;
    logic                  flag_q;
    logic [15:0]           code_q;

    logic                  take;
    logic                  beat;
    logic                  last_beat;
    logic signed [16:0]    ns;
    logic                  cnt_bad;
    logic                  rng_bad;
    logic [17:0]           src_w;
    logic [17:0]           dst_w;
    logic [31:0]           clamp_y;
    logic                  clamp_bad;
    logic [15:0]           bit_mask;
    logic [63:0]           src_ext;

    assign take      = cmd_i.valid && !busy_q;
    assign beat      = src_valid_i && rdy_q;
    assign last_beat = beat && (cnt_q == WBM_CNT_W'(1));
    assign ns        = $signed({1'b0, cmd_i.count});
    assign bit_mask  = 16'h0001 << cmd_i.count[3:0];

    wbm_clamp #(
        .W      (32)
    ) u_clamp (
        .lo_i   (cmd_i.opa),
        .hi_i   (cmd_i.opb),
        .x_i    (cmd_i.opc),
        .y_o    (clamp_y),
        .bad_o  (clamp_bad)
    );

    // count and index limits per operation
    always_comb begin
        case (cmd_i.op)
            nibble_pack_op:    cnt_bad = ns < 17'sd1 || cmd_i.count > WBM_PACK_MAX;
            block_sum_op:      cnt_bad = ns < 17'sd1 || cmd_i.count > WBM_SUM_MAX;
            block_sum_wide_op: cnt_bad = ns < 17'sd1 || cmd_i.count > WBM_SUM_WIDE_MAX;
            bit_set_op,
            bit_clear_op:      cnt_bad = cmd_i.count > WBM_BIT_MAX;
            block_reset_op:    cnt_bad = ns < 17'sd1 || cmd_i.count > WBM_BLOCK_RESET_OP_MAX;
            default:           cnt_bad = 1'b0;
        endcase
    end

    // block footprints in words
    always_comb begin
        case (cmd_i.op)
            nibble_pack_op:    begin src_w = {2'h0, cmd_i.count};       dst_w = 18'h1; end
            block_sum_op:      begin src_w = {2'h0, cmd_i.count};       dst_w = 18'h2; end
            block_sum_wide_op: begin src_w = {1'h0, cmd_i.count, 1'b0}; dst_w = 18'h4; end
            block_reset_op:    begin src_w = 18'h0; dst_w = {2'h0, cmd_i.count}; end
            bound_clamp_wide_op: begin src_w = 18'h0; dst_w = 18'h2; end
            default:           begin src_w = 18'h0; dst_w = 18'h1; end
        endcase
    end

    always_comb begin
        rng_bad = ({2'h0, cmd_i.dst} + dst_w - 18'h1) > {2'h0, cmd_i.dst_end};
        if (src_w != 18'h0 && ({2'h0, cmd_i.src} + src_w - 18'h1) > {2'h0, cmd_i.src_end}) begin
            rng_bad = 1'b1;
        end
        // crossed bounds count as range fault
        if (cmd_i.op == bound_clamp_wide_op && clamp_bad) begin
            rng_bad = 1'b1;
        end
    end

    // narrow sources sign extend from bit 15
    always_comb begin
        if (op_q == block_sum_wide_op) begin
            src_ext = {{32{src_data_i[31]}}, src_data_i};
        end else begin
            src_ext = {{48{src_data_i[15]}}, src_data_i[15:0]};
        end
    end

    assign acc_d  = acc_q + src_ext;
    always_comb begin
        pack_d = pack_q;
        pack_d[nib_q*WBM_NIB_W +: WBM_NIB_W] = src_data_i[WBM_NIB_W-1:0];
    end

    // sequencing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            op_q    <= nibble_pack_op;
            tc_q    <= 1'b0;
            cnt_q   <= '0;
            addr_q  <= 16'h0000;
            busy_q  <= 1'b0;
            rdy_q   <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (take && !cnt_bad && !rng_bad) begin
                        op_q   <= cmd_i.op;
                        tc_q   <= cmd_i.tc_target;
                        cnt_q  <= cmd_i.count[WBM_CNT_W-1:0];
                        addr_q <= cmd_i.dst;
                        if (cmd_i.op == block_reset_op) begin
                            state_q <= ST_CLEAR;
                            busy_q  <= 1'b1;
                        end else if (cmd_i.op == nibble_pack_op || cmd_i.op == block_sum_op
                                     || cmd_i.op == block_sum_wide_op) begin
                            state_q <= ST_FETCH;
                            busy_q  <= 1'b1;
                            rdy_q   <= 1'b1;
                        end
                    end
                end
                ST_FETCH: begin
                    if (beat) begin
                        cnt_q <= cnt_q - WBM_CNT_W'(1);
                    end
                    if (last_beat) begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                        rdy_q   <= 1'b0;
                    end
                end
                ST_CLEAR: begin
                    cnt_q  <= cnt_q - WBM_CNT_W'(1);
                    addr_q <= addr_q + 16'h0001;
                    if (cnt_q == WBM_CNT_W'(1)) begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                    rdy_q   <= 1'b0;
                end
            endcase
        end
    end

    // gathered data
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q  <= 64'h0;
            pack_q <= 16'h0000;
            nib_q  <= 2'h0;
        end else if (state_q == ST_IDLE) begin
            acc_q  <= 64'h0;
            pack_q <= 16'h0000;
            nib_q  <= 2'h0;
        end else if (beat) begin
            acc_q  <= acc_d;
            pack_q <= pack_d;
            nib_q  <= nib_q + 2'h1;
        end
    end

    // destination writes; error paths only pulse done here, never write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q   <= '0;
            done_q <= 1'b0;
        end else begin
            wr_q.en      <= 1'b0;
            wr_q.aux_clr <= 1'b0;
            done_q       <= 1'b0;
            if (state_q == ST_IDLE && take) begin
                done_q    <= cnt_bad || rng_bad;
                wr_q.addr <= cmd_i.dst;
                wr_q.len  <= WBM_LEN_WORD;
                if (!cnt_bad && !rng_bad) begin
                    case (cmd_i.op)
                        bit_set_op: begin
                            wr_q.en   <= 1'b1;
                            wr_q.data <= {48'h0, cmd_i.opa[15:0] | bit_mask};
                            done_q    <= 1'b1;
                        end
                        bit_clear_op: begin
                            wr_q.en   <= 1'b1;
                            wr_q.data <= {48'h0, cmd_i.opa[15:0] & ~bit_mask};
                            done_q    <= 1'b1;
                        end
                        bound_clamp_wide_op: begin
                            wr_q.en   <= 1'b1;
                            wr_q.len  <= WBM_LEN_DOUBLE;
                            wr_q.data <= {32'h0, clamp_y};
                            done_q    <= 1'b1;
                        end
                        default: begin
                            wr_q.en <= 1'b0;
                        end
                    endcase
                end
            end else if (state_q == ST_FETCH && last_beat) begin
                wr_q.en   <= 1'b1;
                wr_q.addr <= addr_q;
                done_q    <= 1'b1;
                if (op_q == nibble_pack_op) begin
                    wr_q.len  <= WBM_LEN_WORD;
                    wr_q.data <= {48'h0, pack_d};
                end else if (op_q == block_sum_wide_op) begin
                    wr_q.len  <= WBM_LEN_LONG;
                    wr_q.data <= acc_d;
                end else begin
                    wr_q.len  <= WBM_LEN_DOUBLE;
                    wr_q.data <= {32'h0, acc_d[31:0]};
                end
            end else if (state_q == ST_CLEAR) begin
                wr_q.en      <= 1'b1;
                wr_q.addr    <= addr_q;
                wr_q.len     <= WBM_LEN_WORD;
                wr_q.data    <= 64'h0;
                wr_q.aux_clr <= tc_q;
                done_q       <= cnt_q == WBM_CNT_W'(1);
            end
        end
    end

    // error flag and code; a new fault wins over a clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
            code_q <= WBM_ERR_CODE_RST;
        end else if (take && (cnt_bad || rng_bad)) begin
            flag_q <= 1'b1;
            // operand code first, range code otherwise
            code_q <= cnt_bad ? WBM_ERR_OPERAND : WBM_ERR_RANGE;
        end else if (err_clr_i) begin
            flag_q <= 1'b0;
        end
    end

    assign busy_o                 = busy_q;
    assign done_o                 = done_q;
    assign src_ready_o            = rdy_q;
    assign wr_o                   = wr_q;
    assign operation_error_flag_o = flag_q;
    assign error_code_register_o  = code_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_PACK_BAD_COUNT: assert property (
        take && cmd_i.op == nibble_pack_op && cmd_i.count > WBM_PACK_MAX
        |=> operation_error_flag_o && error_code_register_o == 16'h200B)
        else $error("pack count fault not flagged");
    AST_OPERAND_CODE: assert property (
        take && cnt_bad |=> error_code_register_o == 16'h200B && done_o)
        else $error("operand fault code wrong");
    AST_RANGE_CODE: assert property (
        take && !cnt_bad && rng_bad |=> error_code_register_o == 16'h2003 && !wr_o.en)
        else $error("range fault code wrong");
    AST_NO_WRITE_ON_FAULT: assert property (
        take && (cnt_bad || rng_bad) |=> !wr_o.en && !busy_o ##1 (!wr_o.en || $past(take)))
        else $error("write after failed check");
    AST_BIT_SET: assert property (
        take && cmd_i.op == bit_set_op && !cnt_bad && !rng_bad
        |=> wr_o.en && wr_o.data[15:0] == ($past(cmd_i.opa[15:0]) | $past(bit_mask)))
        else $error("bit set result wrong");
    AST_BIT_CLEAR: assert property (
        take && cmd_i.op == bit_clear_op && !cnt_bad && !rng_bad
        |=> wr_o.en && wr_o.data[15:0] == ($past(cmd_i.opa[15:0]) & ~$past(bit_mask)))
        else $error("bit clear result wrong");
    AST_BIT_INDEX: assert property (
        take && (cmd_i.op == bit_set_op || cmd_i.op == bit_clear_op) && cmd_i.count > 16'h000F
        |=> !wr_o.en && operation_error_flag_o)
        else $error("bad bit index not refused");
    AST_CLEAR_ZERO: assert property (
        state_q == ST_CLEAR |=> wr_o.en && wr_o.data == 64'h0 && wr_o.addr == $past(addr_q))
        else $error("block reset write wrong");
    AST_CLEAR_AUX: assert property (
        state_q == ST_CLEAR |=> wr_o.aux_clr == $past(tc_q))
        else $error("contact clear missing");
    AST_SUM_LEN: assert property (
        state_q == ST_FETCH && last_beat && op_q != nibble_pack_op
        |=> wr_o.len == ($past(op_q) == block_sum_wide_op ? WBM_LEN_LONG : WBM_LEN_DOUBLE))
        else $error("sum width wrong");
    AST_CLAMP_RANGE: assert property (
        take && cmd_i.op == bound_clamp_wide_op && !cnt_bad && !rng_bad
        |=> $signed(wr_o.data[31:0]) >= $signed($past(cmd_i.opa))
            && $signed(wr_o.data[31:0]) <= $signed($past(cmd_i.opb)))
        else $error("clamp out of bounds");
    AST_CLAMP_ORDER: assert property (
        take && cmd_i.op == bound_clamp_wide_op && clamp_bad
        |=> error_code_register_o == 16'h2003 && !wr_o.en)
        else $error("crossed bounds not refused");

    COV_PACK: cover property (state_q == ST_FETCH && last_beat && op_q == nibble_pack_op);
    COV_WIDE_SUM: cover property (state_q == ST_FETCH && last_beat && op_q == block_sum_wide_op);
    COV_RESET: cover property (state_q == ST_CLEAR && tc_q ##1 state_q == ST_CLEAR);
    COV_FAULT: cover property (take && cnt_bad);
endmodule
`default_nettype wire

// ===== test/wbm_src_model.sv
// source word stream model of the sequencer side
`timescale 1ns/10ps
`default_nettype none
module wbm_src_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // stream to the unit
    input  wire logic        src_ready_i,
    output logic             src_valid_o,
    output logic [31:0]      src_data_o
);
    logic [31:0] mem [0:255];
    int          n_words = 0;
    int          idx     = 0;
    int          cyc     = 0;
    bit          slow    = 0;
    bit          hit;
    initial begin
        src_valid_o = 1'b0;
        src_data_o  = 32'h0;
    end
    task automatic load(input int n, input bit stall);
        n_words = n;
        idx     = 0;
        slow    = stall;
    endtask
    // a beat stays offered until taken; idle data toggles so stale values never match
    always @(posedge clk_i) begin
        hit = src_valid_o && src_ready_i;
        if (hit) idx++;
        if (!rst_n_i) idx = n_words;
        cyc++;
        #1;
        if (src_valid_o && !hit) begin
            src_valid_o = 1'b1;
        end else if (idx < n_words && !(slow && cyc % 3 == 0)) begin
            src_valid_o = 1'b1;
            src_data_o  = mem[idx];
        end else begin
            src_valid_o = 1'b0;
            src_data_o  = ~src_data_o;
        end
    end
endmodule
`default_nettype wire

// ===== test/word_bit_manipulation_unit_tb.sv
// self-checking bench of the word and bit manipulation unit
`timescale 1ns/10ps
`default_nettype none
module word_bit_manipulation_unit_tb;
    import wbm_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    wbm_cmd_s    cmd = '0;
    logic        busy_o, done_o, src_valid, src_ready, err_clr = 1'b0, flag;
    logic [31:0] src_data;
    logic [15:0] code;
    wbm_wr_s     wr_o;
    wbm_wr_s     wq[$];
    logic [31:0] src_q[$];
    int          err_total = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          seed = 32'h86a0ad1a;
    logic [63:0] e;
    logic [31:0] w;
    longint      s;

    always #20 clk_i = ~clk_i;

    wbm_unit #(.DW(32)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .busy_o(busy_o),
        .done_o(done_o), .src_valid_i(src_valid), .src_data_i(src_data),
        .src_ready_o(src_ready), .wr_o(wr_o), .err_clr_i(err_clr),
        .operation_error_flag_o(flag), .error_code_register_o(code));
    wbm_src_model i_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_ready_i(src_ready),
        .src_valid_o(src_valid), .src_data_o(src_data));

    // writes are sampled mid-cycle, away from the launching edge
    always @(negedge clk_i) if (wr_o.en === 1'b1) wq.push_back(wr_o);

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic feed(input int n, input bit stall);
        src_q.delete();
        for (int k = 0; k < n; k++) begin
            src_q.push_back($random(seed));
            i_src.mem[k] = src_q[k];
        end
        i_src.load(n, stall);
    endtask

    task automatic run(input wbm_op_e op, input logic [15:0] n, input logic [31:0] a,
                       input logic [31:0] b, input logic [31:0] c);
        int t;
        wq.delete();
        @(posedge clk_i);
        #1;
        cmd.valid = 1'b1;
        cmd.op    = op;
        cmd.count = n;
        cmd.opa   = a;
        cmd.opb   = b;
        cmd.opc   = c;
        @(posedge clk_i);
        #1;
        cmd.valid = 1'b0;
        t = 0;
        while (done_o !== 1'b1 && t < 2000) begin
            @(negedge clk_i);
            t++;
        end
        chk(64'(t < 2000), 64'h1);
        // mid-cycle write capture must land before anyone reads the queue
        @(posedge clk_i);
        #1;
        chk(64'({busy_o, done_o}), 64'h0);
    endtask

    task automatic ok(input logic [63:0] d, input wbm_len_e len, input logic [63:0] m);
        wbm_wr_s r;
        r = (wq.size() > 0) ? wq[0] : '0;
        chk(64'(wq.size()), 64'h1);
        chk(r.data & m, d & m);
        chk(64'(r.len), 64'(len));
        chk(64'(r.addr), 64'(cmd.dst));
        chk(64'(flag), 64'h0);
    endtask

    task automatic bad(input logic [15:0] ecode);
        chk(64'(wq.size()), 64'h0);
        chk(64'(flag), 64'h1);
        chk(64'(code), 64'(ecode));
        @(posedge clk_i);
        #1;
        err_clr = 1'b1;
        @(posedge clk_i);
        #1;
        err_clr = 1'b0;
        chk(64'(flag), 64'h0);
    endtask

    initial begin
        cmd.src = 16'h0000;
        cmd.dst = 16'h0010;
        cmd.src_end = 16'hFFFF;
        cmd.dst_end = 16'hFFFF;
        repeat (12) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        for (int n = 1; n <= 4; n++) begin
            feed(n, n % 2);
            run(nibble_pack_op, 16'(n), 32'h0, 32'h0, 32'h0);
            e = '0;
            for (int k = 0; k < n; k++) e |= 64'(src_q[k] & 32'hF) << (4 * k);
            ok(e, WBM_LEN_WORD, 64'hFFFF);
        end
        // pack counts outside 1..4 are the sequencer's fault
        run(nibble_pack_op, 16'h0000, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        run(nibble_pack_op, 16'h0005, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        $display("test pack done");
        for (int n = 0; n < 4; n++) begin
            feed((n < 2) ? (n ? 256 : 3) : (n == 2 ? 2 : 128), n % 2);
            s = 0;
            foreach (src_q[k]) s += (n < 2) ? longint'($signed(src_q[k][15:0]))
                                            : longint'($signed(src_q[k]));
            if (n < 2) begin
                run(block_sum_op, 16'(src_q.size()), 32'h0, 32'h0, 32'h0);
                ok(64'(s), WBM_LEN_DOUBLE, 64'hFFFF_FFFF);
            end else begin
                run(block_sum_wide_op, 16'(src_q.size()), 32'h0, 32'h0, 32'h0);
                ok(64'(s), WBM_LEN_LONG, 64'hFFFF_FFFF_FFFF_FFFF);
            end
        end
        run(block_sum_op, 16'h0101, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        run(block_sum_wide_op, 16'h0081, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        run(block_sum_op, 16'h0000, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        $display("test sum done");
        w = $random(seed) & 32'h7FFE;
        for (int i = 0; i < 16; i += 15) begin
            run(bit_set_op, 16'(i), w, 32'h0, 32'h0);
            ok(64'(w | (32'h1 << i)), WBM_LEN_WORD, 64'hFFFF);
            w = w | (32'h1 << i);
        end
        run(bit_clear_op, 16'h0003, w | 32'h8, 32'h0, 32'h0);
        ok(64'(w & ~32'h8), WBM_LEN_WORD, 64'hFFFF);
        run(bit_set_op, 16'h0010, w, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        run(bit_clear_op, 16'h0010, w, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        $display("test bit done");
        for (int n = 1; n <= 3; n += 2) begin
            cmd.tc_target = n[1];
            run(block_reset_op, 16'(n), 32'h0, 32'h0, 32'h0);
            chk(64'(wq.size()), 64'(n));
            foreach (wq[k]) begin
                chk(64'(wq[k].addr), 64'(cmd.dst + 16'(k)));
                chk(wq[k].data, 64'h0);
                chk(64'(wq[k].aux_clr), 64'(n[1]));
            end
        end
        run(block_reset_op, 16'h0401, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        run(block_reset_op, 16'h0000, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_OPERAND);
        cmd.src = 16'h00FE;
        cmd.src_end = 16'h00FF;
        run(nibble_pack_op, 16'h0003, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_RANGE);
        cmd.dst_end = 16'h0011;
        run(block_reset_op, 16'h0003, 32'h0, 32'h0, 32'h0);
        bad(WBM_ERR_RANGE);
        cmd.src = 16'h0000;
        cmd.src_end = 16'hFFFF;
        cmd.dst_end = 16'hFFFF;
        $display("test reset and range done");
        for (int k = 0; k < 3; k++) begin
            w = (k == 0) ? -32'sd9 : (k == 1 ? 32'd200 : 32'($random(seed) % 100 + 0));
            e = ($signed(w) < -5) ? -64'sd5 : ($signed(w) > 100 ? 64'd100 : 64'($signed(w)));
            run(bound_clamp_wide_op, 16'h0001, -32'sd5, 32'd100, w);
            ok(e, WBM_LEN_DOUBLE, 64'hFFFF_FFFF);
        end
        run(bound_clamp_wide_op, 16'h0001, 32'd10, 32'd3, 32'd5);
        bad(WBM_ERR_RANGE);
        $display("test clamp done");
        results();
    end
endmodule
`default_nettype wire
